// file: logic/vr_seq_pkg.sv
// Package with constants, types and helper functions of the two-rail power sequencer
// Function
// - Supply-ready rises only with controller and driver supplies above their thresholds.
// - Supply-ready and enable high start both rails together.
// - Controller supply or enable low powers down and disables everything.
// - Serial command interface is ready within 2 ms of enable.
// - Protection latches clear only when supply-ready drops, never by enable.
// - Enable rising edge latches clock and data pins as startup code.
// - Both references soft-start from zero to startup voltage at 3 mV/us.
// - Power good follows a fixed delay once outputs exceed startup minus 300 mV.
// - Telemetry line is driven high while latching and before the interface runs.
// - Rising power-ok starts the serial interface, which then awaits commands.
// - A valid command starts a transition and signals completion at target.
// - Power-ok low stops the interface and returns references to startup voltage.
// - Losing enable drops both power-good outputs at once and starts soft-shutdown.
// - Soft-shutdown ramps references down at soft-start slope in forced CONTINUOUS_CONDUCTION_MODE.
// - Each rail stops switching once its sense voltage crosses about 0.2 V.
// - Startup code clears at supply-ready reset and is resampled at next enable.
// - Serial clock runs 0.1 to 20 MHz; slow clocks may lose telemetry.
// - A protected rail pulls the other rail's power good low after 5 us.
// - Power-ok must rise after enable, else no soft-start and no interface.
// - Without power-ok the serial clock and data inputs are ignored.
package vr_seq_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SOFT_STEP_NS = 1000;
	localparam int SOFT_STEP_CYC = (SOFT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] SOFT_STEP_MV = 12'h003;
	localparam int ON_THE_FLY_TRANSITION_STEP_NS = 80;
	localparam int ON_THE_FLY_TRANSITION_STEP_CYC = (ON_THE_FLY_TRANSITION_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] ON_THE_FLY_TRANSITION_STEP_MV = 12'h001;
	localparam int PG_DELAY_US = 100;
	localparam int PG_DELAY_CYC = PG_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int CROSS_DELAY_US = 5;
	localparam int CROSS_DELAY_CYC = CROSS_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam logic [11:0] PG_MARGIN_MV = 12'h12c;
	localparam logic [11:0] BOOT_00_MV = 12'h44c;
	localparam logic [11:0] BOOT_01_MV = 12'h3e8;
	localparam logic [11:0] BOOT_10_MV = 12'h384;
	localparam logic [11:0] BOOT_11_MV = 12'h320;
	localparam int CODE_ZERO_MV = 1550;
	localparam logic [4:0] HEADER_BITS = 5'h18;
	localparam logic [4:0] PACKET_BITS = 5'h16;
	localparam logic [4:0] CODE_HI_LSB = 5'h0a;
	localparam logic [4:0] CODE_LO_POS = 5'h08;
	localparam int SYNC_W = 19;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_WAIT_EN = 3'h1,
		ST_SOFT_START = 3'h2,
		ST_PG_WAIT = 3'h3,
		ST_ACTIVE = 3'h4,
		ST_SEQ_ERR = 3'h5,
		ST_SHUTDOWN = 3'h6
	} seq_state_type;

	function automatic logic [11:0] boot_mv(input logic [1:0] code);
		case (code)
			2'h0: boot_mv = BOOT_00_MV;
			2'h1: boot_mv = BOOT_01_MV;
			2'h2: boot_mv = BOOT_10_MV;
			default: boot_mv = BOOT_11_MV;
		endcase
	endfunction

	function automatic logic [11:0] code_to_mv(input logic [7:0] code);
		int drop;
		drop = (int'(code) * 25) / 4;
		if (drop >= CODE_ZERO_MV) begin
			code_to_mv = 12'h000;
		end else begin
			code_to_mv = 12'(CODE_ZERO_MV - drop);
		end
	endfunction
endpackage

// file: logic/level_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
module level_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_type;

	sync_state_type s_ff;
	sync_state_type nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.meta = async_i;
		nxt_s.stable = s_ff.meta;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sync_o = s_ff.stable;
endmodule

// file: logic/serial_cmd_rx.sv
// Serial voltage command receiver in the serial clock domain
`timescale 1ns/100ps
module serial_cmd_rx (
	input wire logic serial_vid_clock_i,
	input wire logic rst_n_i,
	input wire logic serial_vid_data_i,
	input wire logic run_i,
	output logic [9:0] cmd_word_o,
	output logic cmd_toggle_o
);
	typedef struct packed {
		logic run_meta;
		logic run;
		logic [26:0] shift;
		logic busy;
		logic [4:0] count;
		logic [9:0] word;
		logic toggle;
	} rx_state_type;

	rx_state_type s_ff;
	rx_state_type nxt_s;
	logic [26:0] shifted;

	always_comb begin
		nxt_s = s_ff;
		shifted = {s_ff.shift[25:0], serial_vid_data_i};
		nxt_s.run_meta = run_i;
		nxt_s.run = s_ff.run_meta;
		if (!s_ff.run) begin
			nxt_s.busy = 1'b0;
			nxt_s.count = 5'h00;
		end else begin
			nxt_s.shift = shifted;
			if (!s_ff.busy) begin
				if (shifted[4:0] == vr_seq_pkg::HEADER_BITS) begin
					nxt_s.busy = 1'b1;
					nxt_s.count = 5'h00;
				end
			end else if (s_ff.count == vr_seq_pkg::PACKET_BITS - 5'h01) begin
				nxt_s.busy = 1'b0;
				nxt_s.word = {shifted[21], shifted[20],
					shifted[vr_seq_pkg::CODE_HI_LSB +: 7],
					shifted[vr_seq_pkg::CODE_LO_POS]};
				nxt_s.toggle = ~s_ff.toggle;
			end else begin
				nxt_s.count = s_ff.count + 5'h01;
			end
		end
	end

	always_ff @(posedge serial_vid_clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign cmd_word_o = s_ff.word;
	assign cmd_toggle_o = s_ff.toggle;
endmodule

// file: logic/vr_power_sequencer.sv
// Start-up, command and shut-down sequencer for two regulator rails
`timescale 1ns/100ps
module vr_power_sequencer (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic controller_supply_ok_i,
	input wire logic driver_supply_ok_i,
	input wire logic enable_i,
	input wire logic platform_power_ok_i,
	input wire logic serial_vid_clock_i,
	input wire logic serial_vid_data_i,
	input wire logic core_above_pg_i,
	input wire logic secondary_above_pg_i,
	input wire logic core_below_stop_i,
	input wire logic secondary_below_stop_i,
	input wire logic core_over_voltage_i,
	input wire logic core_over_current_i,
	input wire logic core_under_voltage_i,
	input wire logic secondary_over_voltage_i,
	input wire logic secondary_over_current_i,
	input wire logic secondary_under_voltage_i,
	output logic [11:0] core_ref_mv_o,
	output logic [11:0] secondary_ref_mv_o,
	output logic [11:0] pg_threshold_mv_o,
	output logic core_switching_o,
	output logic secondary_switching_o,
	output logic continuous_conduction_mode_o,
	output logic core_power_good_o,
	output logic core_power_good_oe_o,
	output logic secondary_power_good_o,
	output logic secondary_power_good_oe_o,
	output logic telemetry_line_o,
	output logic serial_ready_o,
	output logic interface_running_o,
	output logic transition_done_o,
	output logic [1:0] startup_voltage_code_o,
	output logic [2:0] core_latches_o,
	output logic [2:0] secondary_latches_o,
	output logic sequence_fault_o
);
	typedef struct packed {
		vr_seq_pkg::seq_state_type state;
		logic [1:0] boot_code;
		logic boot_valid;
		logic [11:0] core_ref;
		logic [11:0] sec_ref;
		logic [11:0] core_tgt;
		logic [11:0] sec_tgt;
		logic [4:0] step_cnt;
		logic [11:0] pg_cnt;
		logic [7:0] cross_cnt;
		logic core_pg;
		logic sec_pg;
		logic [2:0] core_lat;
		logic [2:0] sec_lat;
		logic core_sw;
		logic sec_sw;
		logic continuous_conduction_mode;
		logic running;
		logic on_the_fly_transition_busy;
		logic on_the_fly_transition_done;
		logic telemetry;
		logic en_q;
		logic pok_q;
		logic tog_q;
	} seq_regs_type;

	seq_regs_type s_ff;
	seq_regs_type nxt_s;

	logic [vr_seq_pkg::SYNC_W-1:0] raw_in;
	logic [vr_seq_pkg::SYNC_W-1:0] syn;
	logic [9:0] cmd_word;
	logic cmd_toggle;

	logic sup_ready;
	logic en;
	logic pok;
	logic pin_clk;
	logic pin_data;
	logic core_pg_in;
	logic sec_pg_in;
	logic core_stop;
	logic sec_stop;
	logic [2:0] core_faults;
	logic [2:0] sec_faults;
	logic tog;
	logic en_rise;
	logic pok_rise;
	logic cmd_new;
	logic core_fault;
	logic sec_fault;
	logic step_now;
	logic [4:0] step_period;
	logic at_target;

	// Every asynchronous level passes two flops first
	assign raw_in = {controller_supply_ok_i, driver_supply_ok_i, enable_i,
		platform_power_ok_i, serial_vid_clock_i, serial_vid_data_i,
		core_above_pg_i, secondary_above_pg_i, core_below_stop_i,
		secondary_below_stop_i, core_over_voltage_i, core_over_current_i,
		core_under_voltage_i, secondary_over_voltage_i,
		secondary_over_current_i, secondary_under_voltage_i, cmd_toggle,
		1'b0, 1'b0};

	level_sync #(
		.W(vr_seq_pkg::SYNC_W)
	) u_sync (
		.clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(raw_in),
		.sync_o(syn)
	);

	serial_cmd_rx u_rx (
		.serial_vid_clock_i(serial_vid_clock_i),
		.rst_n_i(rst_n_i),
		.serial_vid_data_i(serial_vid_data_i),
		.run_i(s_ff.running),
		.cmd_word_o(cmd_word),
		.cmd_toggle_o(cmd_toggle)
	);

	assign sup_ready = syn[18] & syn[17];
	assign en = syn[16];
	assign pok = syn[15];
	assign pin_clk = syn[14];
	assign pin_data = syn[13];
	assign core_pg_in = syn[12];
	assign sec_pg_in = syn[11];
	assign core_stop = syn[10];
	assign sec_stop = syn[9];
	assign core_faults = syn[8:6];
	assign sec_faults = syn[5:3];
	assign tog = syn[2];

	function automatic logic [11:0] ramp(input logic [11:0] cur, input logic [11:0] tgt,
		input logic [11:0] amt);
		if (cur < tgt) begin
			ramp = (tgt - cur > amt) ? cur + amt : tgt;
		end else begin
			ramp = (cur - tgt > amt) ? cur - amt : tgt;
		end
	endfunction

	always_comb begin
		nxt_s = s_ff;
		en_rise = en & ~s_ff.en_q;
		pok_rise = pok & ~s_ff.pok_q;
		cmd_new = tog ^ s_ff.tog_q;
		nxt_s.en_q = en;
		nxt_s.pok_q = pok;
		nxt_s.tog_q = tog;
		nxt_s.on_the_fly_transition_done = 1'b0;
		core_fault = |s_ff.core_lat;
		sec_fault = |s_ff.sec_lat;
		step_period = s_ff.on_the_fly_transition_busy ? 5'(vr_seq_pkg::ON_THE_FLY_TRANSITION_STEP_CYC) :
			5'(vr_seq_pkg::SOFT_STEP_CYC);
		step_now = (s_ff.step_cnt >= step_period - 5'h01);
		at_target = (s_ff.core_ref == s_ff.core_tgt) && (s_ff.sec_ref == s_ff.sec_tgt);
		nxt_s.step_cnt = step_now ? 5'h00 : s_ff.step_cnt + 5'h01;
		if (step_now && !at_target) begin
			// Soft slope for start and stop, faster slope while a command is applied
			nxt_s.core_ref = ramp(s_ff.core_ref, s_ff.core_tgt,
				s_ff.on_the_fly_transition_busy ? vr_seq_pkg::ON_THE_FLY_TRANSITION_STEP_MV : vr_seq_pkg::SOFT_STEP_MV);
			nxt_s.sec_ref = ramp(s_ff.sec_ref, s_ff.sec_tgt,
				s_ff.on_the_fly_transition_busy ? vr_seq_pkg::ON_THE_FLY_TRANSITION_STEP_MV : vr_seq_pkg::SOFT_STEP_MV);
		end
		nxt_s.core_lat = s_ff.core_lat | core_faults;
		nxt_s.sec_lat = s_ff.sec_lat | sec_faults;

		case (s_ff.state)
			vr_seq_pkg::ST_OFF: begin
				nxt_s.state = vr_seq_pkg::ST_WAIT_EN;
			end
			vr_seq_pkg::ST_WAIT_EN: begin
				if (en_rise) begin
					if (!s_ff.boot_valid) begin
						nxt_s.boot_code = {pin_clk, pin_data};
						nxt_s.boot_valid = 1'b1;
					end
					nxt_s.telemetry = 1'b1;
					if (pok) begin
						nxt_s.state = vr_seq_pkg::ST_SEQ_ERR;
					end else begin
						nxt_s.state = vr_seq_pkg::ST_SOFT_START;
						nxt_s.core_ref = 12'h000;
						nxt_s.sec_ref = 12'h000;
						nxt_s.core_tgt = vr_seq_pkg::boot_mv(s_ff.boot_valid ?
							s_ff.boot_code : {pin_clk, pin_data});
						nxt_s.sec_tgt = vr_seq_pkg::boot_mv(s_ff.boot_valid ?
							s_ff.boot_code : {pin_clk, pin_data});
						nxt_s.step_cnt = 5'h00;
						nxt_s.core_sw = 1'b1;
						nxt_s.sec_sw = 1'b1;
						nxt_s.continuous_conduction_mode = 1'b1;
					end
				end
			end
			vr_seq_pkg::ST_SOFT_START: begin
				if (at_target && core_pg_in && sec_pg_in) begin
					nxt_s.state = vr_seq_pkg::ST_PG_WAIT;
					nxt_s.pg_cnt = 12'h000;
				end
			end
			vr_seq_pkg::ST_PG_WAIT: begin
				if (s_ff.pg_cnt == 12'(vr_seq_pkg::PG_DELAY_CYC - 1)) begin
					nxt_s.state = vr_seq_pkg::ST_ACTIVE;
					nxt_s.core_pg = ~core_fault;
					nxt_s.sec_pg = ~sec_fault;
				end else begin
					nxt_s.pg_cnt = s_ff.pg_cnt + 12'h001;
				end
			end
			vr_seq_pkg::ST_ACTIVE: begin
				if (pok_rise && !s_ff.running) begin
					nxt_s.running = 1'b1;
					nxt_s.telemetry = 1'b0;
				end else if (!pok && s_ff.running) begin
					nxt_s.running = 1'b0;
					nxt_s.telemetry = 1'b1;
					nxt_s.core_tgt = vr_seq_pkg::boot_mv(s_ff.boot_code);
					nxt_s.sec_tgt = vr_seq_pkg::boot_mv(s_ff.boot_code);
					nxt_s.on_the_fly_transition_busy = 1'b0;
					nxt_s.continuous_conduction_mode = 1'b1;
				end else if (cmd_new && s_ff.running && pok) begin
					// Commands only count while the interface runs
					if (cmd_word[9]) begin
						nxt_s.core_tgt = vr_seq_pkg::code_to_mv(cmd_word[7:0]);
					end
					if (cmd_word[8]) begin
						nxt_s.sec_tgt = vr_seq_pkg::code_to_mv(cmd_word[7:0]);
					end
					if (cmd_word[9] || cmd_word[8]) begin
						nxt_s.on_the_fly_transition_busy = 1'b1;
						nxt_s.continuous_conduction_mode = 1'b1;
						nxt_s.step_cnt = 5'h00;
					end
				end else if (s_ff.on_the_fly_transition_busy && at_target) begin
					nxt_s.on_the_fly_transition_busy = 1'b0;
					nxt_s.on_the_fly_transition_done = 1'b1;
				end else if (!s_ff.on_the_fly_transition_busy && at_target && s_ff.running) begin
					nxt_s.continuous_conduction_mode = 1'b0;
				end
			end
			vr_seq_pkg::ST_SEQ_ERR: begin
				nxt_s.core_sw = 1'b0;
				nxt_s.sec_sw = 1'b0;
			end
			vr_seq_pkg::ST_SHUTDOWN: begin
				nxt_s.continuous_conduction_mode = 1'b1;
				if (core_stop) begin
					nxt_s.core_sw = 1'b0;
				end
				if (sec_stop) begin
					nxt_s.sec_sw = 1'b0;
				end
				if (at_target && !s_ff.core_sw && !s_ff.sec_sw) begin
					nxt_s.state = vr_seq_pkg::ST_WAIT_EN;
					nxt_s.continuous_conduction_mode = 1'b0;
				end
			end
			default: begin
				nxt_s.state = vr_seq_pkg::ST_OFF;
			end
		endcase

		// Protected rail drops its own good at once, the other after a delay
		if (core_fault) begin
			nxt_s.core_pg = 1'b0;
		end
		if (sec_fault) begin
			nxt_s.sec_pg = 1'b0;
		end
		if (core_fault || sec_fault) begin
			if (s_ff.cross_cnt == 8'(vr_seq_pkg::CROSS_DELAY_CYC - 1)) begin
				nxt_s.core_pg = 1'b0;
				nxt_s.sec_pg = 1'b0;
			end else begin
				nxt_s.cross_cnt = s_ff.cross_cnt + 8'h01;
			end
		end

		// Enable loss: goods low now, then ramp down
		if (!en && (s_ff.state == vr_seq_pkg::ST_SOFT_START ||
			s_ff.state == vr_seq_pkg::ST_PG_WAIT || s_ff.state == vr_seq_pkg::ST_ACTIVE ||
			s_ff.state == vr_seq_pkg::ST_SEQ_ERR)) begin
			nxt_s.state = vr_seq_pkg::ST_SHUTDOWN;
			nxt_s.core_pg = 1'b0;
			nxt_s.sec_pg = 1'b0;
			nxt_s.running = 1'b0;
			nxt_s.telemetry = 1'b1;
			nxt_s.on_the_fly_transition_busy = 1'b0;
			nxt_s.continuous_conduction_mode = 1'b1;
			nxt_s.core_tgt = 12'h000;
			nxt_s.sec_tgt = 12'h000;
		end

		// Supply-ready loss clears everything, startup code and latches too
		if (!sup_ready) begin
			nxt_s = '0;
			nxt_s.state = vr_seq_pkg::ST_OFF;
			nxt_s.boot_valid = 1'b0;
			nxt_s.core_lat = 3'h0;
			nxt_s.sec_lat = 3'h0;
			nxt_s.en_q = en;
			nxt_s.pok_q = pok;
			nxt_s.tog_q = tog;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign core_ref_mv_o = s_ff.core_ref;
	assign secondary_ref_mv_o = s_ff.sec_ref;
	assign pg_threshold_mv_o = s_ff.boot_valid ?
		vr_seq_pkg::boot_mv(s_ff.boot_code) - vr_seq_pkg::PG_MARGIN_MV : 12'h000;
	assign core_switching_o = s_ff.core_sw;
	assign secondary_switching_o = s_ff.sec_sw;
	assign continuous_conduction_mode_o = s_ff.continuous_conduction_mode;
	// Open-drain goods: driven low while not good
	assign core_power_good_o = 1'b0;
	assign core_power_good_oe_o = ~s_ff.core_pg;
	assign secondary_power_good_o = 1'b0;
	assign secondary_power_good_oe_o = ~s_ff.sec_pg;
	// Completion shown as a one-cycle high on telemetry; slow serial clocks may miss it
	assign telemetry_line_o = s_ff.telemetry | s_ff.on_the_fly_transition_done;
	assign serial_ready_o = s_ff.boot_valid && (s_ff.state == vr_seq_pkg::ST_ACTIVE ||
		s_ff.state == vr_seq_pkg::ST_PG_WAIT || s_ff.state == vr_seq_pkg::ST_SOFT_START);
	assign interface_running_o = s_ff.running;
	assign transition_done_o = s_ff.on_the_fly_transition_done;
	assign startup_voltage_code_o = s_ff.boot_code;
	assign core_latches_o = s_ff.core_lat;
	assign secondary_latches_o = s_ff.sec_lat;
	assign sequence_fault_o = (s_ff.state == vr_seq_pkg::ST_SEQ_ERR);
endmodule

// file: verif/vr_seq_checker.sv
// Port-level assertions for the power sequencer
`timescale 1ns/100ps
module vr_seq_checker (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic controller_supply_ok_i,
	input wire logic driver_supply_ok_i,
	input wire logic enable_i,
	input wire logic platform_power_ok_i,
	input wire logic [11:0] core_ref_mv_o,
	input wire logic [11:0] pg_threshold_mv_o,
	input wire logic core_switching_o,
	input wire logic core_power_good_oe_o,
	input wire logic secondary_power_good_oe_o,
	input wire logic telemetry_line_o,
	input wire logic serial_ready_o,
	input wire logic interface_running_o,
	input wire logic transition_done_o,
	input wire logic [1:0] startup_voltage_code_o,
	input wire logic [2:0] core_latches_o,
	input wire logic sequence_fault_o
);
	logic [11:0] boot_mv;
	always_comb begin
		case (startup_voltage_code_o)
			2'h0: boot_mv = vr_seq_pkg::BOOT_00_MV;
			2'h1: boot_mv = vr_seq_pkg::BOOT_01_MV;
			2'h2: boot_mv = vr_seq_pkg::BOOT_10_MV;
			default: boot_mv = vr_seq_pkg::BOOT_11_MV;
		endcase
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	pg_level_a: assert property (
		serial_ready_o |-> pg_threshold_mv_o == boot_mv - vr_seq_pkg::PG_MARGIN_MV)
		else $error("power good threshold wrong");
	ref_step_a: assert property (
		core_switching_o && $past(core_switching_o)
		|-> 12'(core_ref_mv_o - $past(core_ref_mv_o) + 12'h003) <= 12'h006)
		else $error("reference step too large");
	ena_fall_a: assert property (
		$fell(enable_i) |-> ##[1:4] (core_power_good_oe_o && secondary_power_good_oe_o))
		else $error("goods not pulled at enable loss");
	ena_low_a: assert property (
		!enable_i [*5] |-> core_power_good_oe_o && secondary_power_good_oe_o)
		else $error("good released without enable");
	run_pok_a: assert property (
		$rose(interface_running_o) |-> $past(platform_power_ok_i) && !sequence_fault_o)
		else $error("interface started without power-ok");
	pok_low_a: assert property (
		!platform_power_ok_i [*4] |-> !interface_running_o)
		else $error("interface runs without power-ok");
	tele_high_a: assert property (
		serial_ready_o && !interface_running_o |-> telemetry_line_o)
		else $error("telemetry low before interface runs");
	done_pulse_a: assert property (
		transition_done_o |=> !transition_done_o)
		else $error("completion longer than one cycle");
	cross_pg_a: assert property (
		$rose(|core_latches_o) && !secondary_power_good_oe_o
		|-> ##1 !secondary_power_good_oe_o [*8] ##[100:130] secondary_power_good_oe_o)
		else $error("other good delay wrong");
	latch_hold_a: assert property (
		controller_supply_ok_i && driver_supply_ok_i && $past(controller_supply_ok_i)
		&& $past(driver_supply_ok_i)
		|-> (core_latches_o & $past(core_latches_o)) == $past(core_latches_o))
		else $error("latch cleared with supply up");
endmodule

// file: verif/svi_master.sv
// Processor serial master and platform power-ok model
`timescale 1ns/100ps
module svi_master (
	input wire logic sys_clk_i,
	output logic serial_vid_clock_o,
	output logic serial_vid_data_o,
	output logic platform_power_ok_o
);
	initial begin
		serial_vid_clock_o = 1'h0;
		serial_vid_data_o = 1'h0;
		platform_power_ok_o = 1'h0;
	end
	// Power-ok set on the next clock; the bench also raises it once before enable
	task automatic set_pok(input logic v);
		@(posedge sys_clk_i);
		platform_power_ok_o <= v;
	endtask
	// Idle pin levels, clock stands still
	task automatic set_pins(input logic [1:0] v);
		@(posedge sys_clk_i);
		serial_vid_clock_o <= v[1];
		serial_vid_data_o <= v[0];
	endtask
	// Frame at 8 MHz with idle lead-in; data moves while clock low
	task automatic send(input logic cs, input logic ns, input logic [7:0] c);
		logic [29:0] b;
		b = {3'h0, 5'h18, cs, ns, 3'h1, c[7:1], 1'h0, c[0], 8'h00};
		serial_vid_clock_o = 1'h0;
		for (int i = 29; i >= 0; i--) begin
			serial_vid_data_o = b[i];
			#62.5 serial_vid_clock_o = 1'h1;
			#62.5 serial_vid_clock_o = 1'h0;
		end
		serial_vid_data_o = ~b[0];
	endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the two-rail power sequencer
`timescale 1ns/100ps
module tb;
	logic sys_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic controller_supply_ok_i = 1'h0;
	logic driver_supply_ok_i = 1'h0;
	logic en = 1'h0;
	logic [1:0] abv = 2'h0;
	logic [1:0] blw = 2'h0;
	logic [5:0] flt = 6'h00;
	logic pok, serial_vid_clock, serial_vid_data, csw, ssw, continuous_conduction_mode, co, so, tel, rdy, run, done, sf, cpd, spd;
	logic [11:0] cr, sr, thr;
	logic [1:0] code;
	logic [2:0] cl, sl;
	int miscompares = 0;
	int cmp_count = 0;
	int seed = 46958;
	int cycles = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	svi_master PM (.sys_clk_i, .serial_vid_clock_o(serial_vid_clock), .serial_vid_data_o(serial_vid_data),
		.platform_power_ok_o(pok));
	vr_power_sequencer DUT (.sys_clk_i, .rst_n_i, .controller_supply_ok_i,
		.driver_supply_ok_i, .enable_i(en), .platform_power_ok_i(pok),
		.serial_vid_clock_i(serial_vid_clock), .serial_vid_data_i(serial_vid_data), .core_above_pg_i(abv[0]),
		.secondary_above_pg_i(abv[1]), .core_below_stop_i(blw[0]),
		.secondary_below_stop_i(blw[1]), .core_over_voltage_i(flt[2]),
		.core_over_current_i(flt[1]), .core_under_voltage_i(flt[0]),
		.secondary_over_voltage_i(flt[5]), .secondary_over_current_i(flt[4]),
		.secondary_under_voltage_i(flt[3]), .core_ref_mv_o(cr), .secondary_ref_mv_o(sr),
		.pg_threshold_mv_o(thr), .core_switching_o(csw), .secondary_switching_o(ssw),
		.continuous_conduction_mode_o(continuous_conduction_mode), .core_power_good_o(cpd),
		.core_power_good_oe_o(co), .secondary_power_good_o(spd),
		.secondary_power_good_oe_o(so), .telemetry_line_o(tel), .serial_ready_o(rdy),
		.interface_running_o(run), .transition_done_o(done),
		.startup_voltage_code_o(code), .core_latches_o(cl), .secondary_latches_o(sl),
		.sequence_fault_o(sf));
	function automatic logic [11:0] boot_exp(input logic [1:0] c);
		return (c == 2'h0) ? 12'h44c : (c == 2'h1) ? 12'h3e8 : (c == 2'h2) ? 12'h384 : 12'h320;
	endfunction
	function automatic logic [11:0] cmd_exp(input logic [7:0] c);
		int d;
		d = int'(c) * 25 / 4;
		return (d >= vr_seq_pkg::CODE_ZERO_MV) ? 12'h000 : 12'(vr_seq_pkg::CODE_ZERO_MV - d);
	endfunction
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'h1) begin
			miscompares++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic boot(input logic [1:0] c);
		int n;
		logic [11:0] mv;
		mv = boot_exp(c);
		PM.set_pins(c);
		cyc(2);
		chk(!rdy && !csw, "started before enable");
		en <= 1'h1;
		cyc(5);
		PM.set_pins(~c);
		chk(code === c && thr === mv - 12'h12c, "startup code");
		chk(tel && csw && ssw && continuous_conduction_mode && rdy, "soft start entry");
		n = 6;
		while (cr !== mv && n < 12000) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(n >= (mv + 2) / 3 * 25 - 25 && n <= (mv + 2) / 3 * 25 + 10, "ramp time");
		chk(sr === mv && code === c, "secondary ramp");
		abv <= 2'h1;
		cyc(200);
		chk(co && so, "good with one rail low");
		abv <= 2'h3;
		cyc(2490);
		chk(co && so, "good too early");
		cyc(30);
		chk(!co && !so, "good not released");
	endtask
	task automatic cmd(input logic cs, input logic ns, input logic [7:0] v);
		int n;
		logic [11:0] c0, s0;
		c0 = cs ? cmd_exp(v) : cr;
		s0 = ns ? cmd_exp(v) : sr;
		PM.send(cs, ns, v);
		n = 0;
		while (done !== 1'h1 && n < 4000) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(n < 4000 && cr === c0 && sr === s0, "transition target");
	endtask
	task automatic shut();
		int n;
		logic [11:0] r;
		abv <= 2'h0;
		en <= 1'h0;
		cyc(4);
		chk(co && so && cpd === 1'h0 && spd === 1'h0, "goods at enable loss");
		r = cr;
		cyc(30);
		chk(cr <= r - 12'h003 && cr >= r - 12'h006 && continuous_conduction_mode, "shutdown slope");
		blw <= 2'h1;
		cyc(5);
		chk(!csw && ssw, "core stop at low sense");
		blw <= 2'h3;
		n = 0;
		while (cr !== 12'h000 && n < 12000) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(sr === 12'h000 && !ssw, "shutdown end");
		blw <= 2'h0;
	endtask
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			chk(1'h0, "timeout");
			wrap_up();
		end
	end
	initial begin
		logic [1:0] bc;
		logic [7:0] v;
		int f;
		int n;
		bc = 2'($random(seed));
		cyc(10);
		rst_n_i <= 1'h1;
		controller_supply_ok_i <= 1'h1;
		cyc(3);
		en <= 1'h1;
		cyc(6);
		chk(!csw && !rdy, "start without driver supply");
		en <= 1'h0;
		driver_supply_ok_i <= 1'h1;
		cyc(4);
		boot(bc);
		PM.set_pok(1'h1);
		cyc(4);
		chk(run && !tel, "interface start");
		for (int k = 0; k < 2; k++) begin
			v = 8'($random(seed));
			cmd(1'h1, k == 0, v);
		end
		PM.set_pok(1'h0);
		cyc(4);
		chk(!run && tel, "interface stop");
		PM.send(1'h1, 1'h1, 8'h00);
		n = 0;
		while ((cr !== boot_exp(bc) || sr !== boot_exp(bc)) && n < 10000) begin
			@(posedge sys_clk_i);
			n++;
		end
		cyc(200);
		chk(n < 10000 && {cr, sr} === {2{boot_exp(bc)}}, "startup voltage");
		f = $unsigned($random(seed)) % 6;
		flt[f] <= 1'h1;
		cyc(2);
		flt <= 6'h00;
		cyc(8);
		chk({sl, cl} === 6'h01 << f, "fault latch");
		chk(f < 3 ? co && !so : so && !co, "own good dropped");
		cyc(130);
		chk(co === 1'h1 && so === 1'h1, "other good dropped");
		shut();
		chk({sl, cl} === 6'h01 << f, "latch kept without enable");
		controller_supply_ok_i <= 1'h0;
		cyc(5);
		chk({sl, cl, code} === 8'h00 && !csw, "supply drop clears");
		controller_supply_ok_i <= 1'h1;
		PM.set_pins(~bc);
		PM.set_pok(1'h1);
		cyc(3);
		en <= 1'h1;
		cyc(8);
		chk(sf && !csw && !rdy && !run && code === ~bc, "power-ok before enable");
		en <= 1'h0;
		PM.set_pok(1'h0);
		cyc(5);
		boot(~bc);
		shut();
		wrap_up();
	end
endmodule
bind vr_power_sequencer vr_seq_checker CHK (.sys_clk_i, .rst_n_i, .controller_supply_ok_i,
	.driver_supply_ok_i, .enable_i, .platform_power_ok_i, .core_ref_mv_o,
	.pg_threshold_mv_o, .core_switching_o, .core_power_good_oe_o,
	.secondary_power_good_oe_o, .telemetry_line_o, .serial_ready_o, .interface_running_o,
	.transition_done_o, .startup_voltage_code_o, .core_latches_o, .sequence_fault_o);
